// ===== hw/alc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module alc_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         srst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } alc_fifo_st_t;

    alc_fifo_st_t st;
    alc_fifo_st_t next_st;
    logic [W-1:0] mem [0:D-1];
    logic         push;
    logic         pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign in_ready  = (st.cnt != (AW+1)'(D));
    assign out_valid = (st.cnt != '0);
    assign out_data  = mem[st.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = bump(st.wp);
        end
        if (pop) begin
            next_st.rp = bump(st.rp);
        end
        next_st.cnt = (AW+1)'(st.cnt + push - pop);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
        if (push) begin
            mem[st.wp] <= in_data;
        end
    end
endmodule // alc_fifo

// ===== hw/alc_line_ctrl.sv
// Four-port asynchronous line controller: shared 9-bit message memory, two
// transmitter-receiver channels of two ports each, and modem leads per port.
// Assumes pins are asynchronous to clk and the host follows the ack handshake.
`timescale 1ns/1ps
`include "alc_map.svh"
// Function
// - Serves four asynchronous RS232 ports, two per channel.
// - Host fills a shared 4K by 9-bit memory with outbound bytes.
// - Access controller grants the memory to host or local side, one at once.
// - Sending starts after the whole message is stored (code takes tx_start whenever the reader is idle); bytes go without their stored ninth bit.
// - Two transmitter-receivers share the internal bus; one selected per transfer.
// - Frame is start bit, eight data bits, optional parity, two stop bits.
// - Serial output idles at mark, logic 1, outside characters.
// - Selected receiver turns serial input into a byte stored in memory.
// - Parity generator adds the parity bit before a received byte is stored.
// - After storing received data the host is told data is ready.
// - Non-data leads go through the selected channel and port.
module alc_line_ctrl #(
    parameter logic [15:0] BAUD_DIV = `ALC_BAUD_DIV
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   srst,
    // Host memory port
    input  wire logic                   host_req,
    input  wire logic                   host_we,
    input  wire logic [`ALC_MEM_AW-1:0] host_addr,
    input  wire logic [8:0]             host_wdata,
    output logic                        host_ack,
    output logic [8:0]                  host_rdata,
    // Message transmit control
    input  wire logic                   tx_start,
    input  wire logic [`ALC_MEM_AW-1:0] tx_base,
    input  wire logic [`ALC_MEM_AW:0]   tx_len,
    output logic                        tx_busy,
    output logic                        tx_done,
    // Receive notification
    input  wire logic                   rx_ack,
    output logic                        rx_ready,
    output logic [`ALC_RX_PW-1:0]       rx_wptr,
    output logic                        rx_frame_err,
    // Configuration and selected-port leads
    input  wire logic                   cfg_parity_en,
    input  wire logic                   cfg_parity_odd,
    input  wire logic                   sel_chan,
    input  wire logic                   sel_port,
    input  wire logic                   ctl_write,
    input  wire logic                   ctl_rts,
    input  wire logic                   ctl_dtr,
    input  wire logic                   ctl_sca,
    output logic [4:0]                  sel_status,
    // Port pins, index is channel*2+port
    output logic [3:0]                  port_tx_serial_out,
    input  wire logic [3:0]             port_rx_serial_in,
    output logic [3:0]                  port_send_request_out,
    output logic [3:0]                  port_terminal_ready_out,
    output logic [3:0]                  port_second_control_out,
    input  wire logic [3:0]             port_set_ready_in,
    input  wire logic [3:0]             port_clear_send_in,
    input  wire logic [3:0]             port_ring_in,
    input  wire logic [3:0]             port_carrier_in,
    input  wire logic [3:0]             port_second_carrier_in
);
    localparam logic [15:0] HALF = BAUD_DIV >> 1;

    alc_pkg::alc_st_t st;
    alc_pkg::alc_st_t next_st;
    logic [8:0]       mem [0:(1 << `ALC_MEM_AW)-1];
    logic [8:0]       mem_q;
    logic [`ALC_MEM_AW-1:0] mem_addr;
    logic [8:0]       mem_wd;
    logic             mem_we;
    logic             loc_req;
    logic             host_gnt;
    logic             loc_gnt;
    logic             rx_gnt;
    logic             rd_gnt;
    logic             fifo_in_ready;
    logic             fifo_out_valid;
    logic             fifo_out_ready;
    logic [7:0]       fifo_out_data;
    logic             fifo_pop;
    logic [1:0]       sel_idx;
    logic             rx_line;

    function automatic logic par_bit(input logic [7:0] d, input logic odd);
        return (^d) ^ odd;
    endfunction

    assign sel_idx = {sel_chan, sel_port};
    assign rx_line = st.rx_s2[sel_idx];

    assign loc_req  = st.rx_wr_pend ||
                      (st.rd == alc_pkg::ALC_RD_RUN && !st.rd_pend && !st.push_v &&
                       fifo_in_ready && st.rd_left != '0);
    assign host_gnt = host_req && !st.host_hold && (!loc_req || !st.last_host);
    assign loc_gnt  = loc_req && !host_gnt;
    assign rx_gnt   = loc_gnt && st.rx_wr_pend;
    assign rd_gnt   = loc_gnt && !st.rx_wr_pend;

    assign mem_addr = host_gnt ? host_addr :
                      rx_gnt ? `ALC_MEM_AW'(`ALC_RX_BASE + st.rx_wptr) : st.rd_ptr;
    assign mem_we   = (host_gnt && host_we) || rx_gnt;
    assign mem_wd   = host_gnt ? host_wdata : st.rx_wr_d;

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wd;
        end
        mem_q <= mem[mem_addr];
    end

    // common bus to the channel of the current message
    assign fifo_out_ready = (st.rd != alc_pkg::ALC_RD_IDLE) && !st.tx[st.msg_chan].busy;
    assign fifo_pop       = fifo_out_valid && fifo_out_ready;

    // Decouples memory arbitration stalls from the bit timing of the line
    alc_fifo #(
        .W(`ALC_FIFO_W),
        .D(`ALC_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .srst     (srst),
        .in_valid (st.push_v),
        .in_ready (fifo_in_ready),
        .in_data  (st.push_d),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data (fifo_out_data)
    );

    always_comb begin
        next_st           = st;
        next_st.host_ack  = host_gnt;
        next_st.host_hold = host_gnt;
        next_st.done      = 1'b0;
        next_st.rx_err    = 1'b0;
        if (host_gnt || loc_gnt) begin
            next_st.last_host = host_gnt;
        end
        // start is taken whenever the reader is idle; storing the message first is left to the host
        case (st.rd)
            alc_pkg::ALC_RD_IDLE: begin
                if (tx_start) begin
                    next_st.msg_chan = sel_chan;
                    next_st.msg_port = sel_port;
                    next_st.rd_ptr   = tx_base;
                    next_st.rd_left  = tx_len;
                    next_st.rd       = alc_pkg::ALC_RD_RUN;
                end
            end
            alc_pkg::ALC_RD_RUN: begin
                if (st.rd_left == '0 && !st.rd_pend && !st.push_v) begin
                    next_st.rd = alc_pkg::ALC_RD_DRAIN;
                end
            end
            alc_pkg::ALC_RD_DRAIN: begin
                if (!fifo_out_valid && !st.tx[st.msg_chan].busy) begin
                    next_st.rd   = alc_pkg::ALC_RD_IDLE;
                    next_st.done = 1'b1;
                end
            end
            default: next_st.rd = alc_pkg::ALC_RD_IDLE;
        endcase
        if (rd_gnt) begin
            next_st.rd_pend = 1'b1;
            next_st.rd_ptr  = `ALC_MEM_AW'(st.rd_ptr + 1'b1);
            next_st.rd_left = (`ALC_MEM_AW+1)'(st.rd_left - 1'b1);
        end
        // parity bit dropped on the way to the bus
        if (st.rd_pend) begin
            next_st.rd_pend = 1'b0;
            next_st.push_v  = 1'b1;
            next_st.push_d  = mem_q[7:0];
        end else if (st.push_v && fifo_in_ready) begin
            next_st.push_v = 1'b0;
        end
        next_st.busy = (next_st.rd != alc_pkg::ALC_RD_IDLE);
        for (int c = 0; c < 2; c++) begin
            if (st.tx[c].busy) begin
                if (st.tx[c].cnt == '0) begin
                    next_st.tx[c].cnt   = BAUD_DIV - 16'h0001;
                    next_st.tx[c].shift = {1'b1, st.tx[c].shift[11:1]};
                    next_st.tx[c].bits  = st.tx[c].bits - 4'h1;
                    if (st.tx[c].bits == 4'h1) begin
                        next_st.tx[c].busy = 1'b0;
                    end
                end else begin
                    next_st.tx[c].cnt = st.tx[c].cnt - 16'h0001;
                end
            end else if (fifo_pop && st.msg_chan == c[0]) begin
                next_st.tx[c].busy = 1'b1;
                next_st.tx[c].port = st.msg_port;
                next_st.tx[c].cnt  = BAUD_DIV - 16'h0001;
                // start, data, optional parity, two stops
                if (cfg_parity_en) begin
                    next_st.tx[c].shift = {2'b11, par_bit(fifo_out_data, cfg_parity_odd), fifo_out_data, 1'b0};
                    next_st.tx[c].bits  = `ALC_FRAME_PAR;
                end else begin
                    next_st.tx[c].shift = {3'b111, fifo_out_data, 1'b0};
                    next_st.tx[c].bits  = `ALC_FRAME_NOP;
                end
            end
        end
        // mark unless this port carries a character
        for (int p = 0; p < `ALC_NPORT; p++) begin
            next_st.txo[p] = !(st.tx[p/2].busy && st.tx[p/2].port == p[0]) || st.tx[p/2].shift[0];
        end
        // all four lines and lead groups brought through two stages
        next_st.rx_s1  = port_rx_serial_in;
        next_st.rx_s2  = st.rx_s1;
        next_st.sts_s1 = {port_second_carrier_in, port_carrier_in, port_ring_in,
                          port_clear_send_in, port_set_ready_in};
        next_st.sts_s2 = st.sts_s1;
        // receiver on the selected channel and port
        case (st.rx)
            alc_pkg::ALC_RX_IDLE: begin
                if (!rx_line) begin
                    next_st.rx     = alc_pkg::ALC_RX_START;
                    next_st.rx_cnt = HALF;
                end
            end
            alc_pkg::ALC_RX_START: begin
                if (st.rx_cnt != '0) begin
                    next_st.rx_cnt = st.rx_cnt - 16'h0001;
                end else if (rx_line) begin
                    next_st.rx = alc_pkg::ALC_RX_IDLE;
                end else begin
                    next_st.rx      = alc_pkg::ALC_RX_BITS;
                    next_st.rx_cnt  = BAUD_DIV - 16'h0001;
                    next_st.rx_bits = '0;
                end
            end
            alc_pkg::ALC_RX_BITS: begin
                if (st.rx_cnt != '0) begin
                    next_st.rx_cnt = st.rx_cnt - 16'h0001;
                end else begin
                    next_st.rx_cnt  = BAUD_DIV - 16'h0001;
                    next_st.rx_bits = st.rx_bits + 4'h1;
                    // Received parity is sampled past but not kept
                    if (st.rx_bits < 4'h8) begin
                        next_st.rx_sh = {rx_line, st.rx_sh[7:1]};
                    end
                    if (st.rx_bits == (cfg_parity_en ? 4'h8 : 4'h7)) begin
                        next_st.rx = alc_pkg::ALC_RX_STOP;
                    end
                end
            end
            alc_pkg::ALC_RX_STOP: begin
                if (st.rx_cnt != '0) begin
                    next_st.rx_cnt = st.rx_cnt - 16'h0001;
                end else begin
                    next_st.rx = alc_pkg::ALC_RX_IDLE;
                    if (rx_line) begin
                        next_st.rx_wr_pend = 1'b1;
                        next_st.rx_wr_d = {cfg_parity_en && par_bit(st.rx_sh, cfg_parity_odd), st.rx_sh};
                    end else begin
                        next_st.rx_err = 1'b1;
                    end
                end
            end
            default: next_st.rx = alc_pkg::ALC_RX_IDLE;
        endcase
        // ready set by a store wins over the host clear
        if (rx_ack) begin
            next_st.rx_ready = 1'b0;
        end
        if (rx_gnt) begin
            next_st.rx_wr_pend = 1'b0;
            next_st.rx_wptr    = `ALC_RX_PW'(st.rx_wptr + 1'b1);
            next_st.rx_ready   = 1'b1;
        end
        // control leads written through the selected port
        if (ctl_write) begin
            next_st.rts[sel_idx] = ctl_rts;
            next_st.dtr[sel_idx] = ctl_dtr;
            next_st.sca[sel_idx] = ctl_sca;
        end
        // status of the selected port made readable
        for (int k = 0; k < 5; k++) begin
            next_st.sel_sts[k] = st.sts_s2[k*4 + int'(sel_idx)];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st     <= '0;
            st.txo <= 4'hF;
            // Synchronisers start at mark so release of reset is no false start bit
            st.rx_s1 <= 4'hF;
            st.rx_s2 <= 4'hF;
        end else begin
            st <= next_st;
        end
    end

    assign host_ack                = st.host_ack;
    assign host_rdata              = mem_q;
    assign tx_busy                 = st.busy;
    assign tx_done                 = st.done;
    assign rx_ready                = st.rx_ready;
    assign rx_wptr                 = st.rx_wptr;
    assign rx_frame_err            = st.rx_err;
    assign sel_status              = st.sel_sts;
    assign port_tx_serial_out      = st.txo;
    assign port_send_request_out   = st.rts;
    assign port_terminal_ready_out = st.dtr;
    assign port_second_control_out = st.sca;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_ONE_GRANT: assert property (!(host_gnt && loc_gnt))
        else $error("host and local granted together");
    AST_HOST_ACK: assert property (host_gnt |=> host_ack ##1 !host_ack)
        else $error("host ack not a single pulse after grant");
    AST_NO_EARLY_TX: assert property ((st.rd == alc_pkg::ALC_RD_IDLE) |-> !fifo_pop)
        else $error("byte sent without a started message");
    AST_TX_MARK: assert property (!st.tx[0].busy && !st.tx[1].busy |=> port_tx_serial_out == 4'hF)
        else $error("line not marking while idle");
    AST_START_BIT: assert property ($rose(st.tx[0].busy) && !st.tx[0].port
                                    |=> !port_tx_serial_out[0] && port_tx_serial_out[1])
        else $error("start bit missing on channel 0 port 0");
    AST_CHAN_SEL: assert property (fifo_pop |=> st.tx[st.msg_chan].busy)
        else $error("selected channel did not take the byte");
    AST_RX_STORE: assert property (st.rx == alc_pkg::ALC_RX_STOP && st.rx_cnt == '0 && rx_line
                                   |=> st.rx_wr_pend ##[0:4] rx_ready)
        else $error("received byte not stored");
    AST_RX_PARITY: assert property (st.rx_wr_pend && cfg_parity_en && $stable(cfg_parity_odd)
                                    |-> st.rx_wr_d[8] == par_bit(st.rx_wr_d[7:0], cfg_parity_odd))
        else $error("stored parity bit wrong");
    AST_READY: assert property (rx_gnt |=> rx_ready && rx_wptr == $past(rx_wptr) + 1'b1)
        else $error("data ready not raised after store");
    AST_CTL_LEAD: assert property (ctl_write && sel_idx == 2'h3 |=> port_send_request_out[3] == $past(ctl_rts)
                                   && port_terminal_ready_out[3] == $past(ctl_dtr))
        else $error("control lead not routed to selected port");
    AST_STATUS: assert property ($stable(sel_idx) [*4] |-> sel_status[2] == $past(port_ring_in[sel_idx], 3))
        else $error("ring status not seen on selected port");

    COV_TX_DONE: cover property (tx_busy ##[1:1000] tx_done);
    COV_RX_STORE: cover property (rx_gnt);
    COV_CONFLICT: cover property (host_req && loc_req && !st.host_hold);
    COV_FRAME_ERR: cover property (rx_frame_err);
endmodule // alc_line_ctrl

// ===== hw/alc_map.svh
// Constants of the four-port asynchronous line controller.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ALC_MAP_SVH
`define ALC_MAP_SVH
`define ALC_NPORT      4
`define ALC_MEM_AW     12
`define ALC_MEM_DW     9
`define ALC_RX_BASE    12'hC00
`define ALC_RX_PW      8
`define ALC_BAUD_DIV   16'h0364
`define ALC_FIFO_W     8
`define ALC_FIFO_DEPTH 8
`define ALC_FRAME_PAR  4'hC
`define ALC_FRAME_NOP  4'hB
`endif

// ===== hw/alc_pkg.sv
// Types shared by the line controller files.
// Assumes alc_map.svh is on the include path.
`include "alc_map.svh"
package alc_pkg;
    typedef enum logic [1:0] {
        ALC_RD_IDLE  = 2'h0,
        ALC_RD_RUN   = 2'h1,
        ALC_RD_DRAIN = 2'h3
    } alc_rd_t;

    typedef enum logic [1:0] {
        ALC_RX_IDLE  = 2'h0,
        ALC_RX_START = 2'h1,
        ALC_RX_BITS  = 2'h3,
        ALC_RX_STOP  = 2'h2
    } alc_rx_t;

    typedef struct packed {
        logic        busy;
        logic        port;
        logic [11:0] shift;
        logic [3:0]  bits;
        logic [15:0] cnt;
    } alc_tx_t;

    typedef struct packed {
        alc_rd_t                rd;
        logic [`ALC_MEM_AW-1:0] rd_ptr;
        logic [`ALC_MEM_AW:0]   rd_left;
        logic                   rd_pend;
        logic                   push_v;
        logic [7:0]             push_d;
        logic                   msg_chan;
        logic                   msg_port;
        logic                   busy;
        logic                   done;
        alc_tx_t [1:0]          tx;
        logic [3:0]             txo;
        alc_rx_t                rx;
        logic [15:0]            rx_cnt;
        logic [3:0]             rx_bits;
        logic [7:0]             rx_sh;
        logic                   rx_wr_pend;
        logic [8:0]             rx_wr_d;
        logic [`ALC_RX_PW-1:0]  rx_wptr;
        logic                   rx_ready;
        logic                   rx_err;
        logic [3:0]             rx_s1;
        logic [3:0]             rx_s2;
        logic [19:0]            sts_s1;
        logic [19:0]            sts_s2;
        logic [4:0]             sel_sts;
        logic [3:0]             rts;
        logic [3:0]             dtr;
        logic [3:0]             sca;
        logic                   host_ack;
        logic                   host_hold;
        logic                   last_host;
    } alc_st_t;
endpackage

// ===== tb/alc_line_ctrl_bench.sv
// Self-checking bench: host port, transmit, receive and lead scenarios.
// Assumes the terminal model on all ports; inputs change at the falling edge.
`timescale 1ns/1ps
`include "alc_map.svh"
module alc_line_ctrl_bench;
    localparam int BIT = 16;
    logic        clk, srst, host_req, host_we, host_ack, tx_start, tx_busy, tx_done, rx_ack, rx_ready;
    logic        rx_frame_err, cfg_parity_en, cfg_parity_odd, sel_chan, sel_port, ctl_write, ctl_rts, ctl_dtr, ctl_sca;
    logic [11:0] host_addr, tx_base;
    logic [12:0] tx_len;
    logic [8:0]  host_wdata, host_rdata;
    logic [7:0]  rx_wptr;
    logic [4:0]  sel_status;
    logic [3:0]  txo, rxi, rts, dtr, sca, dsr, cts, ring, car, scar;
    int          errors, checks;

    alc_line_ctrl #(.BAUD_DIV(16'h0010)) alc_line_ctrl_i (
        .clk, .srst, .host_req, .host_we, .host_addr, .host_wdata, .host_ack, .host_rdata,
        .tx_start, .tx_base, .tx_len, .tx_busy, .tx_done, .rx_ack, .rx_ready, .rx_wptr, .rx_frame_err,
        .cfg_parity_en, .cfg_parity_odd, .sel_chan, .sel_port, .ctl_write, .ctl_rts, .ctl_dtr, .ctl_sca,
        .sel_status, .port_tx_serial_out(txo), .port_rx_serial_in(rxi), .port_send_request_out(rts),
        .port_terminal_ready_out(dtr), .port_second_control_out(sca), .port_set_ready_in(dsr),
        .port_clear_send_in(cts), .port_ring_in(ring), .port_carrier_in(car), .port_second_carrier_in(scar));
    alc_term_model #(.BIT(BIT)) alc_term_model_i (.clk(clk), .line_in(txo), .line_out(rxi));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic hang(input string what);
        errors++;
        $display("[FAIL] %0t %s timed out", $time, what);
        print_verdict();
    endtask

    // Request held until the edge that ends the ack cycle
    task automatic mem(input logic we, input logic [11:0] a, input logic [8:0] d, output logic [8:0] q);
        int t;
        @(negedge clk);
        host_req = 1'b1;
        host_we = we;
        host_addr = a;
        host_wdata = d;
        for (t = 0; t < 20 && host_ack !== 1'b1; t++) @(negedge clk);
        if (t == 20) hang("memory");
        q = host_rdata;
        @(negedge clk);
        host_req = 1'b0;
    endtask

    function automatic logic [7:0] dat(input int idx, input int i);
        return 8'h A5 + 8'(i) * 8'h3B + 8'(idx) * 8'h11;
    endfunction

    // leads written and status read through the selected port
    task automatic t_leads();
        logic [3:0] er, ed, es;
        {er, ed, es} = 12'h000;
        {dsr, cts, ring, car, scar} = 20'h12485;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            {sel_chan, sel_port} = 2'(i);
            {ctl_rts, ctl_dtr, ctl_sca} = 3'h5 ^ 3'(i);
            {er[i], ed[i], es[i]} = 3'h5 ^ 3'(i);
            ctl_write = 1'b1;
            @(negedge clk);
            ctl_write = 1'b0;
            repeat (4) @(negedge clk);
            cmp(16'({rts, dtr, sca}), 16'({er, ed, es}), "leads");
            cmp(16'(sel_status), 16'({scar[i], car[i], ring[i], cts[i], dsr[i]}), "status");
        end
    endtask

    // whole message stored, then framed out on the selected port
    task automatic t_tx(input int idx, input logic pe, input logic po);
        logic [8:0] q;
        logic [7:0] d;
        logic [11:0] f;
        logic ok;
        int t;
        for (int i = 0; i < 3; i++)
            mem(1'b1, 12'(idx * 16 + i), {~pe, dat(idx, i)}, q);
        @(negedge clk);
        cfg_parity_en = pe;
        cfg_parity_odd = po;
        {sel_chan, sel_port} = 2'(idx);
        tx_base = 12'(idx * 16);
        tx_len = 13'h0003;
        tx_start = 1'b1;
        @(negedge clk);
        tx_start = 1'b0;
        cmp(16'(tx_busy), 16'h0001, "busy");
        // host served while the local side reads
        mem(1'b0, 12'(idx * 16 + 1), 9'h000, q);
        cmp(16'(q), 16'({~pe, dat(idx, 1)}), "readback");
        for (int i = 0; i < 3; i++) begin
            d = dat(idx, i);
            alc_term_model_i.recv(idx, pe ? 12 : 11, f, ok);
            if (!ok) hang("frame");
            cmp(16'(f), pe ? {4'h0, 2'h3, (^d) ^ po, d, 1'b0} : {5'h00, 2'h3, d, 1'b0}, "frame");
        end
        cmp(16'(txo | 4'(1 << idx)), 16'h000F, "other lines");
        for (t = 0; t < 100 && tx_done !== 1'b1; t++) @(negedge clk);
        if (t == 100) hang("done");
        repeat (2) @(negedge clk);
        cmp(16'({tx_busy, txo}), 16'h000F, "idle after");
    endtask

    // byte stored at the next slot with generated parity; a bad frame must leave ready low and the slot unchanged
    task automatic t_rx(input int idx, input logic pe, input logic po, input logic [7:0] d, input logic bad);
        logic [8:0] q;
        logic [7:0] p0;
        int t;
        @(negedge clk);
        cfg_parity_en = pe;
        cfg_parity_odd = po;
        {sel_chan, sel_port} = 2'(idx);
        p0 = rx_wptr;
        fork
            alc_term_model_i.send(idx, d, pe | bad, bad ? 1'b0 : (^d) ^ po);
        join_none
        for (t = 0; t < 400 && rx_ready !== 1'b1 && rx_frame_err !== 1'b1; t++) @(negedge clk);
        if (t == 400) hang("receive");
        repeat (3 * BIT) @(negedge clk);
        cmp(16'({rx_ready, rx_wptr}), 16'({~bad, p0 + 8'(!bad)}), "slot");
        if (!bad) begin
            mem(1'b0, `ALC_RX_BASE + 12'(p0), 9'h000, q);
            cmp(16'(q), 16'({pe & ((^d) ^ po), d}), "stored");
            @(negedge clk);
            rx_ack = 1'b1;
            @(negedge clk);
            rx_ack = 1'b0;
            cmp(16'(rx_ready), 16'h0000, "cleared");
        end
    endtask

    initial begin
        errors = 0;
        checks = 0;
        {srst, host_req, host_we, tx_start, rx_ack, cfg_parity_en, cfg_parity_odd} = 7'h40;
        {sel_chan, sel_port, ctl_write, ctl_rts, ctl_dtr, ctl_sca} = 6'h00;
        {host_addr, host_wdata, tx_base, tx_len} = 46'h0;
        {dsr, cts, ring, car, scar} = 20'h00000;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        cmp(16'({txo, rts, dtr, sca}), 16'hF000, "reset");
        t_leads();
        t_tx(3, 1'b1, 1'b1);
        t_tx(0, 1'b1, 1'b0);
        t_tx(1, 1'b0, 1'b0);
        t_rx(2, 1'b1, 1'b1, 8'h5A, 1'b0);
        t_rx(1, 1'b0, 1'b0, 8'hC3, 1'b0);
        t_rx(0, 1'b1, 1'b0, 8'h01, 1'b0);
        t_rx(3, 1'b0, 1'b0, 8'h7E, 1'b1);
        print_verdict();
    end
endmodule // alc_line_ctrl_bench

// ===== tb/alc_term_model.sv
// Terminal model for all four ports: sends and captures asynchronous characters.
// Assumes the bench calls send from a falling edge of clk.
`timescale 1ns/1ps
module alc_term_model #(
    parameter int BIT = 16
) (
    // Clock
    input  wire logic       clk,
    // Serial lines, index is channel*2+port
    input  wire logic [3:0] line_in,
    output logic [3:0]      line_out
);
    initial line_out = 4'hF;

    task automatic send(input int idx, input logic [7:0] b, input logic pen, input logic pb);
        logic [10:0] f;
        f = pen ? {1'b1, pb, b, 1'b0} : {2'h3, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line_out[idx] = f[i];
            repeat (BIT) @(negedge clk);
        end
    endtask

    // Samples n bits mid-bit from the start bit; no wait after the last, so frames may abut
    task automatic recv(input int idx, input int n, output logic [11:0] f, output logic ok);
        int t;
        f = 12'h000;
        ok = 1'b0;
        // Falling edge only: the line is launched at the rising edge
        for (t = 0; t < 5000 && line_in[idx] !== 1'b0; t++) @(negedge clk);
        if (t < 5000) begin
            ok = 1'b1;
            repeat (BIT / 2) @(negedge clk);
            for (int i = 0; i < n; i++) begin
                f[i] = line_in[idx];
                if (i < n - 1) repeat (BIT) @(negedge clk);
            end
        end
    endtask
endmodule // alc_term_model
